// [adc_cal_result_bank.sv]
// calibration and result register bank with its serial register port
`timescale 1ns/1ns
`include "adc_cal_regs.svh"

module adc_cal_result_bank
  import adc_cal_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  // serial register port, sampled as synchronous inputs
  input wire logic csn_in,
  input wire logic sclk_in,
  input wire logic sdi_in,
  output logic sdo_out,
  output logic sdo_oe_out,
  // control bits
  input wire logic cal_readback_select_in,
  input wire logic self_cal_offset_disable_in,
  input wire logic self_cal_gain_disable_in,
  input wire logic system_offset_disable_in,
  input wire logic system_gain_disable_in,
  input wire logic unipolar_in,
  input wire logic format_offset_binary_in,
  input wire logic self_cal_active_in,
  // values kept by the calibration engine and the system calibration bank
  input wire logic [23:0] internal_cal_offset_in,
  input wire logic [23:0] internal_cal_gain_in,
  input wire logic [23:0] system_offset_in,
  input wire logic [23:0] system_gain_value_in,
  // raw conversions from the modulator path
  input wire logic raw_valid_in,
  input wire logic [2:0] raw_channel_in,
  input wire logic [23:0] raw_data_in,
  output logic [23:0] self_cal_offset_out,
  output logic [23:0] self_cal_gain_out,
  output logic result_valid_out
);

  host_port_state_t s_r;
  host_port_state_t s_nxt;

  logic rise;
  logic fall;
  logic [7:0] cmd_now;
  logic [4:0] addr;
  logic is_read;
  logic wr_commit;
  logic [23:0] wr_data;
  logic [23:0] rd_word;
  logic is_result;
  logic [2:0] res_index;
  logic [23:0] mem_rdata;
  logic dp_valid;
  logic [2:0] dp_chan;
  logic [23:0] dp_code;

  assign rise = !csn_in && sclk_in && !s_r.sclk_prev;
  assign fall = !csn_in && !sclk_in && s_r.sclk_prev;
  assign cmd_now = {s_r.cmd[6:0], sdi_in};
  assign addr = s_r.cmd[4:0];
  assign is_read = s_r.cmd[`CMD_READ_BIT];
  assign is_result = (addr >= `ADDR_RESULT_FIRST) && (addr <= `ADDR_RESULT_LAST);
  assign res_index = 3'(addr - `ADDR_RESULT_FIRST);
  assign wr_data = {s_r.shin[22:0], sdi_in};
  // result addresses decode to nothing on a write, so their contents stay put
  assign wr_commit = rise && (s_r.st == ST_DATA) && (s_r.cnt == `FRAME_BITS - 6'h01) && !is_read;

  // readback of the calibration pair follows the select bit
  always_comb begin
    if (addr == `ADDR_SELF_CAL_OFFSET) begin
      rd_word = cal_readback_select_in ? s_r.user_offset : internal_cal_offset_in;
    end else if (addr == `ADDR_SELF_CAL_GAIN) begin
      rd_word = cal_readback_select_in ? s_r.user_gain : internal_cal_gain_in;
    end else if (is_result) begin
      rd_word = mem_rdata;
    end else begin
      rd_word = 24'h000000;
    end
  end

  always_comb begin
    s_nxt = s_r;
    s_nxt.sclk_prev = sclk_in;
    unique case (s_r.st)
      ST_IDLE: begin
        s_nxt.cnt = 6'h00;
        if (!csn_in) begin
          s_nxt.st = ST_CMD;
        end
      end
      ST_CMD: begin
        if (rise) begin
          s_nxt.cmd = cmd_now;
          s_nxt.cnt = s_r.cnt + 6'h01;
          if (s_r.cnt == `CMD_BITS - 6'h01) begin
            s_nxt.st = ST_DATA;
          end
        end
      end
      ST_DATA: begin
        // msb first both ways; bits beyond the frame are ignored
        if (rise && s_r.cnt < `FRAME_BITS) begin
          s_nxt.shin = wr_data;
          s_nxt.cnt = s_r.cnt + 6'h01;
        end
        if (fall && is_read) begin
          if (s_r.cnt == `CMD_BITS) begin
            s_nxt.shout = rd_word;
          end else if (s_r.cnt < `FRAME_BITS) begin
            s_nxt.shout = {s_r.shout[22:0], 1'b0};
          end
        end
      end
      // the fourth code is never entered; fall back to idle if it is
      default: begin
        s_nxt.st = ST_IDLE;
      end
    endcase
    if (csn_in) begin
      s_nxt.st = ST_IDLE;
    end
    // a running self-cal locks both registers; its own results go elsewhere
    if (wr_commit && !self_cal_active_in) begin
      if (addr == `ADDR_SELF_CAL_OFFSET) begin
        s_nxt.user_offset = wr_data;
      end
      if (addr == `ADDR_SELF_CAL_GAIN) begin
        s_nxt.user_gain = wr_data;
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s_r <= '{st: ST_IDLE, sclk_prev: 1'b0, cnt: 6'h00, cmd: 8'h00, shin: 24'h000000, shout: 24'h000000,
               user_offset: `RST_SELF_CAL_OFFSET, user_gain: `RST_SELF_CAL_GAIN};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign sdo_out = s_r.shout[23];
  assign sdo_oe_out = (s_r.st == ST_DATA) && is_read;
  assign self_cal_offset_out = s_r.user_offset;
  assign self_cal_gain_out = s_r.user_gain;
  assign result_valid_out = dp_valid;

  result_corrector u_corrector (
    .clk_sys_in(clk_sys_in),
    .resetn_in(resetn_in),
    .raw_valid_in(raw_valid_in),
    .raw_channel_in(raw_channel_in),
    .raw_data_in(raw_data_in),
    .self_cal_offset_in(s_r.user_offset),
    .self_cal_gain_in(s_r.user_gain),
    .system_offset_in(system_offset_in),
    .system_gain_value_in(system_gain_value_in),
    .self_cal_offset_disable_in(self_cal_offset_disable_in),
    .self_cal_gain_disable_in(self_cal_gain_disable_in),
    .system_offset_disable_in(system_offset_disable_in),
    .system_gain_disable_in(system_gain_disable_in),
    .unipolar_in(unipolar_in),
    .format_offset_binary_in(format_offset_binary_in),
    .res_valid_out(dp_valid),
    .res_channel_out(dp_chan),
    .res_code_out(dp_code)
  );

  // only the corrector writes the store, so host writes cannot reach it
  result_store u_store (
    .clk_sys_in(clk_sys_in),
    .resetn_in(resetn_in),
    .wr_en_in(dp_valid),
    .wr_index_in(dp_chan),
    .wr_data_in(dp_code),
    .rd_index_in(res_index),
    .rd_data_out(mem_rdata)
  );

  property p_offset_write;
    @(posedge clk_sys_in) disable iff (!resetn_in)
    (wr_commit && !self_cal_active_in && addr == `ADDR_SELF_CAL_OFFSET) |=> (s_r.user_offset == $past(wr_data));
  endproperty
  a_offset_write: assert property (p_offset_write)
    else $error("offset register write lost");

  property p_gain_write;
    @(posedge clk_sys_in) disable iff (!resetn_in)
    (wr_commit && !self_cal_active_in && addr == `ADDR_SELF_CAL_GAIN) |=> (s_r.user_gain == $past(wr_data));
  endproperty
  a_gain_write: assert property (p_gain_write)
    else $error("gain register write lost");

  property p_cal_lock;
    @(posedge clk_sys_in) disable iff (!resetn_in)
    self_cal_active_in |=> ($stable(s_r.user_offset) && $stable(s_r.user_gain));
  endproperty
  a_cal_lock: assert property (p_cal_lock)
    else $error("calibration register changed during self-cal");

  property p_user_kept;
    @(posedge clk_sys_in) disable iff (!resetn_in)
    (!wr_commit ##1 !wr_commit) |=> ($stable(s_r.user_offset) && $stable(s_r.user_gain));
  endproperty
  a_user_kept: assert property (p_user_kept)
    else $error("user calibration value changed without a host write");

  property p_readback;
    @(posedge clk_sys_in) disable iff (!resetn_in)
    (fall && s_r.st == ST_DATA && is_read && s_r.cnt == `CMD_BITS && addr == `ADDR_SELF_CAL_OFFSET)
    |=> (s_r.shout == ($past(cal_readback_select_in) ? $past(s_r.user_offset) : $past(internal_cal_offset_in)));
  endproperty
  a_readback: assert property (p_readback)
    else $error("offset readback picked the wrong source");

  property p_result_path;
    @(posedge clk_sys_in) disable iff (!resetn_in)
    raw_valid_in |=> dp_valid ##1 (u_store.s_r.word[$past(dp_chan)] == $past(dp_code));
  endproperty
  a_result_path: assert property (p_result_path)
    else $error("conversion not stored under its channel");

endmodule : adc_cal_result_bank

// [adc_cal_regs.svh]
// register map, reset values and field layout of the calibration and result bank
`ifndef ADC_CAL_REGS_SVH
`define ADC_CAL_REGS_SVH

`define DATA_W 24
`define ADDR_W 5
`define CMD_W 8
`define CMD_READ_BIT 7
`define FRAME_BITS 6'h20
`define CMD_BITS 6'h08

`define ADDR_SELF_CAL_OFFSET 5'h00
`define ADDR_SELF_CAL_GAIN 5'h01
`define ADDR_RESULT_FIRST 5'h02
`define ADDR_RESULT_LAST 5'h07

`define RST_SELF_CAL_OFFSET 24'h000000
`define RST_SELF_CAL_GAIN 24'hbf851b
`define RST_RESULT 24'h000000

`define NUM_CHANNELS 6
`define CHAN_W 3
`define GAIN_FRAC_BITS 23
`define CODE_TC_MAX 24'h7fffff
`define CODE_TC_MIN 24'h800000
`define CODE_OB_MAX 24'hffffff
`define CODE_OB_MIN 24'h000000

`endif

// [adc_cal_pkg.sv]
// types shared by the calibration and result bank
package adc_cal_pkg;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CMD = 2'b01,
    ST_DATA = 2'b11
  } link_state_t;

  typedef struct packed {
    link_state_t st;
    logic sclk_prev;
    logic [5:0] cnt;
    logic [7:0] cmd;
    logic [23:0] shin;
    logic [23:0] shout;
    logic [23:0] user_offset;
    logic [23:0] user_gain;
  } host_port_state_t;

  typedef struct packed {
    logic valid;
    logic [2:0] chan;
    logic [23:0] code;
  } correct_state_t;

  typedef struct packed {
    logic [5:0][23:0] word;
    logic [23:0] rdata;
  } store_state_t;

endpackage : adc_cal_pkg

// [result_store.sv]
// six-entry result memory with registered read data
`timescale 1ns/1ns
`include "adc_cal_regs.svh"

module result_store
  import adc_cal_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  input wire logic wr_en_in,
  input wire logic [2:0] wr_index_in,
  input wire logic [23:0] wr_data_in,
  input wire logic [2:0] rd_index_in,
  output logic [23:0] rd_data_out
);

  store_state_t s_r;
  store_state_t s_nxt;
  logic [5:0] hit;

  // entry n only ever takes channel n
  genvar gi;
  generate
    for (gi = 0; gi < `NUM_CHANNELS; gi++) begin : g_hit
      assign hit[gi] = wr_en_in && (wr_index_in == 3'(gi));
    end
  endgenerate

  always_comb begin
    s_nxt = s_r;
    for (int i = 0; i < `NUM_CHANNELS; i++) begin
      if (hit[i]) begin
        s_nxt.word[i] = wr_data_in;
      end
    end
    s_nxt.rdata = (rd_index_in < 3'(`NUM_CHANNELS)) ? s_r.word[rd_index_in] : `RST_RESULT;
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s_r <= '{word: {6{`RST_RESULT}}, rdata: `RST_RESULT};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rd_data_out = s_r.rdata;

  property p_entry_written;
    @(posedge clk_sys_in) disable iff (!resetn_in)
    (wr_en_in && wr_index_in == 3'h3) |=> (s_r.word[3] == $past(wr_data_in));
  endproperty
  a_entry_written: assert property (p_entry_written)
    else $error("result entry not updated");

  property p_entry_held;
    @(posedge clk_sys_in) disable iff (!resetn_in)
    (!wr_en_in) |=> $stable(s_r.word);
  endproperty
  a_entry_held: assert property (p_entry_held)
    else $error("result entry changed without a conversion");

endmodule : result_store

// [result_corrector.sv]
// correction chain and output coding for one raw conversion per cycle
`timescale 1ns/1ns
`include "adc_cal_regs.svh"

module result_corrector
  import adc_cal_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  input wire logic raw_valid_in,
  input wire logic [2:0] raw_channel_in,
  input wire logic [23:0] raw_data_in,
  input wire logic [23:0] self_cal_offset_in,
  input wire logic [23:0] self_cal_gain_in,
  input wire logic [23:0] system_offset_in,
  input wire logic [23:0] system_gain_value_in,
  input wire logic self_cal_offset_disable_in,
  input wire logic self_cal_gain_disable_in,
  input wire logic system_offset_disable_in,
  input wire logic system_gain_disable_in,
  input wire logic unipolar_in,
  input wire logic format_offset_binary_in,
  output logic res_valid_out,
  output logic [2:0] res_channel_out,
  output logic [23:0] res_code_out
);

  correct_state_t s_r;
  correct_state_t s_nxt;
  // wide enough that nothing wraps before the final clamp
  logic signed [55:0] v;
  logic [23:0] code;

  always_comb begin
    v = 56'(signed'(raw_data_in));
    if (!self_cal_offset_disable_in) begin
      v = v - 56'(signed'(self_cal_offset_in));
    end
    if (!self_cal_gain_disable_in) begin
      v = (v * signed'({32'h0, self_cal_gain_in})) >>> `GAIN_FRAC_BITS;
    end
    if (!system_offset_disable_in) begin
      v = v - 56'(signed'(system_offset_in));
    end
    if (!system_gain_disable_in) begin
      v = (v * signed'({32'h0, system_gain_value_in})) >>> `GAIN_FRAC_BITS;
    end
    // doubling for unipolar comes last, after every offset step
    if (unipolar_in) begin
      v = v <<< 1;
    end
  end

  always_comb begin
    if (unipolar_in) begin
      if (v < 0) begin
        code = `CODE_OB_MIN;
      end else if (v > signed'(56'(`CODE_OB_MAX))) begin
        code = `CODE_OB_MAX;
      end else begin
        code = v[23:0];
      end
    end else begin
      // limits are cast signed: an unsigned limit would make the whole compare unsigned
      if (v < -signed'(56'(`CODE_TC_MIN))) begin
        code = `CODE_TC_MIN;
      end else if (v > signed'(56'(`CODE_TC_MAX))) begin
        code = `CODE_TC_MAX;
      end else begin
        code = v[23:0];
      end
      if (format_offset_binary_in) begin
        code[23] = ~code[23];
      end
    end
  end

  always_comb begin
    s_nxt = s_r;
    s_nxt.valid = raw_valid_in;
    if (raw_valid_in) begin
      s_nxt.chan = raw_channel_in;
      s_nxt.code = code;
    end
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s_r <= '{valid: 1'b0, chan: 3'h0, code: `RST_RESULT};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign res_valid_out = s_r.valid;
  assign res_channel_out = s_r.chan;
  assign res_code_out = s_r.code;

  property p_bypass;
    @(posedge clk_sys_in) disable iff (!resetn_in)
    (raw_valid_in && self_cal_offset_disable_in && self_cal_gain_disable_in && system_offset_disable_in &&
     system_gain_disable_in && !unipolar_in && !format_offset_binary_in)
    |=> (res_valid_out && res_code_out == $past(raw_data_in));
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("disabled corrections altered the result");

  property p_offset_only;
    @(posedge clk_sys_in) disable iff (!resetn_in)
    (raw_valid_in && !self_cal_offset_disable_in && self_cal_gain_disable_in && system_offset_disable_in &&
     system_gain_disable_in && !unipolar_in && !format_offset_binary_in &&
     raw_data_in == 24'h000100 && self_cal_offset_in == 24'h000010)
    |=> (res_code_out == 24'h0000f0);
  endproperty
  a_offset_only: assert property (p_offset_only)
    else $error("self offset not subtracted");

  property p_tc_saturate;
    @(posedge clk_sys_in) disable iff (!resetn_in)
    (raw_valid_in && !unipolar_in && !format_offset_binary_in && v > signed'(56'(`CODE_TC_MAX)))
    |=> (res_code_out == `CODE_TC_MAX);
  endproperty
  a_tc_saturate: assert property (p_tc_saturate)
    else $error("positive overrange wrapped");

  property p_unipolar_floor;
    @(posedge clk_sys_in) disable iff (!resetn_in)
    (raw_valid_in && unipolar_in && v < 0) |=> (res_code_out == `CODE_OB_MIN);
  endproperty
  a_unipolar_floor: assert property (p_unipolar_floor)
    else $error("unipolar underrange not clamped to zero code");

endmodule : result_corrector

// [host_spi_model.sv]
// host-side serial register master acting as the partner of the bank
`timescale 1ns/1ns
module host_spi_model (
  input wire logic clk_sys_in,
  input wire logic sdo_in,
  output logic csn_out,
  output logic sclk_out,
  output logic sdi_out,
  output logic rd_done_out,
  output logic [23:0] rd_word_out
);
  initial begin
    csn_out = 1'b1;
    sclk_out = 1'b0;
    sdi_out = 1'b0;
    rd_done_out = 1'b0;
    rd_word_out = 24'h000000;
  end

  // half is the sclk phase length in clocks; nbits below 32 aborts the frame
  task automatic frame(input logic [7:0] cmd, input logic [23:0] wdata, input int half, input int nbits);
    logic [31:0] w;
    w = {cmd, wdata};
    @(posedge clk_sys_in);
    #1;
    csn_out = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      sdi_out = w[31-i];
      repeat (half) @(posedge clk_sys_in);
      #1;
      // sdo is taken just before the rise, one phase after the fall that shifted it out; it holds until the next fall
      if (i >= 8) rd_word_out = {rd_word_out[22:0], sdo_in};
      sclk_out = 1'b1;
      repeat (half) @(posedge clk_sys_in);
      #1;
      sclk_out = 1'b0;
    end
    repeat (half) @(posedge clk_sys_in);
    #1;
    csn_out = 1'b1;
    // a released data line must not keep showing the last bit
    sdi_out = ~sdi_out;
    if (cmd[7] && nbits == 32) begin
      rd_done_out = 1'b1;
      @(posedge clk_sys_in);
      #1;
      rd_done_out = 1'b0;
    end
  endtask : frame
endmodule : host_spi_model

// [test_adc_calibration_result_registers.sv]
// self-checking bench for the calibration and result register bank
`timescale 1ns/1ns
module test_adc_calibration_result_registers;
  import adc_cal_pkg::*;
  logic clk_sys_in, resetn_in, csn, sclk, sdi, sdo, sdo_oe, rd_done, res_valid;
  logic cal_sel, dis_so, dis_sg, dis_yo, dis_yg, uni, fmt_ob, cal_act, raw_valid;
  logic [2:0] raw_ch;
  logic [23:0] rd_word, int_off, int_gain, sys_off, sys_gain, raw_data, off_out, gain_out, user_off, user_gain;
  logic [23:0] exp_q[$];
  int n_errors = 0;
  int n_tests = 0;

  adc_cal_result_bank DUT (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .csn_in(csn), .sclk_in(sclk),
    .sdi_in(sdi), .sdo_out(sdo), .sdo_oe_out(sdo_oe), .cal_readback_select_in(cal_sel),
    .self_cal_offset_disable_in(dis_so), .self_cal_gain_disable_in(dis_sg),
    .system_offset_disable_in(dis_yo), .system_gain_disable_in(dis_yg), .unipolar_in(uni),
    .format_offset_binary_in(fmt_ob), .self_cal_active_in(cal_act), .internal_cal_offset_in(int_off),
    .internal_cal_gain_in(int_gain), .system_offset_in(sys_off), .system_gain_value_in(sys_gain),
    .raw_valid_in(raw_valid), .raw_channel_in(raw_ch), .raw_data_in(raw_data),
    .self_cal_offset_out(off_out), .self_cal_gain_out(gain_out), .result_valid_out(res_valid));

  host_spi_model host (.clk_sys_in(clk_sys_in), .sdo_in(sdo), .csn_out(csn), .sclk_out(sclk),
    .sdi_out(sdi), .rd_done_out(rd_done), .rd_word_out(rd_word));

  initial begin
    clk_sys_in = 1'b0;
    forever #25 clk_sys_in = ~clk_sys_in;
  end

  task automatic end_sim;
    $display("errors %0d of %0d checks", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_sim

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_flag(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_flag

  // every finished read frame is matched against the oldest note
  always @(posedge clk_sys_in) begin
    if (rd_done === 1'b1) begin
      if (exp_q.size() > 0) chk(rd_word, exp_q.pop_front());
      else n_errors++;
    end
  end

  task automatic rd(input logic [4:0] a, input logic [23:0] e, input int half);
    exp_q.push_back(e);
    fork
      host.frame({3'b100, a}, 24'h000000, half, 32);
      begin
        // the data phase opens one clock after the eighth rise
        repeat (1 + 16 * half) @(posedge clk_sys_in);
        #1;
        chk_flag(sdo_oe, 1'b1);
      end
    join
    chk_flag(sdo_oe, 1'b0);
  endtask : rd

  task automatic wr(input logic [4:0] a, input logic [23:0] d, input int half, input int nbits);
    host.frame({3'b000, a}, d, half, nbits);
  endtask : wr

  function automatic logic [23:0] small_val;
    logic [15:0] r;
    r = 16'($urandom);
    small_val = {{8{r[15]}}, r};
  endfunction : small_val

  // reference correction chain at full width, clamped only at the end
  function automatic logic [23:0] calc(input logic [23:0] raw, input logic [3:0] dis);
    longint v, lo, hi;
    v = longint'($signed(raw));
    if (!dis[0]) v = v - longint'($signed(user_off));
    if (!dis[1]) v = (v * longint'({1'b0, user_gain})) >>> 23;
    if (!dis[2]) v = v - longint'($signed(sys_off));
    if (!dis[3]) v = (v * longint'({1'b0, sys_gain})) >>> 23;
    if (uni) v = v * 64'sh2;
    lo = uni ? 64'sh0 : -64'sh800000;
    hi = uni ? 64'shffffff : 64'sh7fffff;
    if (v < lo) v = lo;
    if (v > hi) v = hi;
    calc = v[23:0];
    if (!uni && fmt_ob) calc[23] = ~calc[23];
  endfunction : calc

  task automatic conv(input logic [2:0] ch, input logic [23:0] d, input logic [23:0] e);
    @(posedge clk_sys_in);
    #1;
    raw_valid = 1'b1;
    raw_ch = ch;
    raw_data = d;
    @(posedge clk_sys_in);
    #1;
    raw_valid = 1'b0;
    raw_data = 24'($urandom);
    chk_flag(res_valid, 1'b1);
    @(posedge clk_sys_in);
    #1;
    chk_flag(res_valid, 1'b0);
    rd(5'h02 + 5'(ch), e, 3);
  endtask : conv

  initial begin
    repeat (60000) @(posedge clk_sys_in);
    n_errors++;
    end_sim();
  end

  initial begin
    logic [23:0] d;
    logic [3:0] dis;
    resetn_in = 1'b0;
    {cal_sel, cal_act, raw_valid, uni, fmt_ob} = 5'b10000;
    {dis_yg, dis_yo, dis_sg, dis_so} = 4'h0;
    {raw_ch, raw_data, sys_off, sys_gain} = {3'h0, 24'h000000, 24'h000000, 24'h800000};
    void'($urandom(28));
    int_off = 24'($urandom);
    int_gain = 24'($urandom);
    repeat (12) @(posedge clk_sys_in);
    #1;
    resetn_in = 1'b1;
    chk(off_out, 24'h000000);
    chk(gain_out, 24'hbf851b);
    rd(5'h00, 24'h000000, 3);
    rd(5'h01, 24'hbf851b, 5);
    for (int a = 2; a < 8; a++) rd(5'(a), 24'h000000, 3);
    user_off = small_val();
    user_gain = 24'h600000 + (24'($urandom) & 24'h3fffff);
    wr(5'h00, user_off, 2, 32);
    wr(5'h01, user_gain, 5, 32);
    chk(off_out, user_off);
    chk(gain_out, user_gain);
    rd(5'h00, user_off, 5);
    cal_sel = 1'b0;
    // with the select bit low the host reads the internal values; the bank passes them straight through
    rd(5'h00, int_off, 3);
    rd(5'h01, int_gain, 3);
    cal_sel = 1'b1;
    cal_act = 1'b1;
    wr(5'h00, ~user_off, 3, 32);
    wr(5'h01, ~user_gain, 3, 32);
    cal_act = 1'b0;
    int_off = ~int_off;
    chk(off_out, user_off);
    chk(gain_out, user_gain);
    rd(5'h01, user_gain, 3);
    wr(5'h00, 24'h0000ff, 3, 20);
    chk(off_out, user_off);
    wr(5'h03, 24'h5a5a5a, 3, 32);
    rd(5'h03, 24'h000000, 3);
    rd(5'h1f, 24'h000000, 3);
    for (int i = 0; i < 16; i++) begin
      dis = (i < 4) ? 4'h0 : 4'($urandom);
      {dis_yg, dis_yo, dis_sg, dis_so} = dis;
      uni = i[1];
      fmt_ob = i[0];
      sys_off = small_val();
      sys_gain = 24'h600000 + (24'($urandom) & 24'h3fffff);
      d = small_val() <<< 6;
      if (i >= 12) begin
        // full-scale input with doubled gain drives both clamps
        {dis_yg, dis_yo, dis_sg, dis_so} = 4'h0;
        dis = 4'h0;
        sys_gain = 24'hffffff;
        d = (i[0] ^ i[1]) ? 24'h800000 : 24'h7fffff;
      end
      conv(3'(i % 6), d, calc(d, dis));
    end
    // offset step alone, then every step bypassed
    wr(5'h00, 24'h000010, 3, 32);
    user_off = 24'h000010;
    {uni, fmt_ob} = 2'b00;
    {dis_yg, dis_yo, dis_sg, dis_so} = 4'he;
    conv(3'h5, 24'h000100, 24'h0000f0);
    {dis_yg, dis_yo, dis_sg, dis_so} = 4'hf;
    conv(3'h4, 24'h876543, 24'h876543);
    if (exp_q.size() != 0) n_errors++;
    end_sim();
  end
endmodule : test_adc_calibration_result_registers
